/* File: tcbd_pkg.sv */
/*
  Constants and types shared by the command block decoder.
  Assumes a single system clock domain and a byte-wide command source.
*/
package tcbd_pkg;

  // ==========================================================
  // command block layout
  localparam int CMD_BYTES = 6;
  localparam logic [2:0] IDX_OPCODE = 3'h0;
  localparam logic [2:0] IDX_UNIT_HI = 3'h1;
  localparam logic [2:0] IDX_ADDR_MID = 3'h2;
  localparam logic [2:0] IDX_ADDR_LO = 3'h3;
  localparam logic [2:0] IDX_COUNT = 3'h4;
  localparam logic [2:0] IDX_OPTION = 3'h5;

  // ==========================================================
  // operation codes
  localparam logic [7:0] OP_TEST_READY = 8'h00;
  localparam logic [7:0] OP_READ_SENSE = 8'h03;
  localparam logic [7:0] OP_DEFINE_PARAMS = 8'h0c;
  localparam logic [7:0] OP_WRITE_BUFFER = 8'h0f;
  localparam logic [7:0] OP_READ_BUFFER = 8'h10;
  localparam logic [7:0] OP_REWIND = 8'h11;
  localparam logic [7:0] OP_READ_BLOCKS = 8'h21;
  localparam logic [7:0] OP_WRITE_BLOCKS = 8'h22;
  localparam logic [7:0] OP_WRITE_MARK = 8'h23;
  localparam logic [7:0] OP_READ_MARKS = 8'h24;
  localparam logic [7:0] OP_READ_EXT_STATUS = 8'h25;
  localparam logic [7:0] OP_ERASE = 8'h26;
  localparam logic [7:0] OP_RETENSION = 8'h27;
  localparam logic [7:0] OP_FIND_END = 8'h28;
  localparam logic [7:0] OP_DIAGNOSTICS = 8'he4;

  // ==========================================================
  // option bit positions
  localparam int OPT_REPOSITION = 7;
  localparam int OPT_FLUSH = 6;
  localparam int OPT_THRESHOLD = 5;
  localparam int OPT_HIGH_CURRENT = 4;
  localparam int OPT_UNDERRUN = 3;
  localparam int OPT_CLEAR_COUNTERS = 2;
  localparam int OPT_PAGE_MSB = 3;

  // byte field positions
  localparam int CLASS_MSB = 7;
  localparam int CLASS_LSB = 5;
  localparam int FUNC_MSB = 4;
  localparam int UNIT_MSB = 7;
  localparam int UNIT_LSB = 5;
  localparam int ADDR_HI_MSB = 4;

  // ==========================================================
  // decoded command identities
  typedef enum logic [3:0] {
    TCBD_CMD_NONE,
    TCBD_CMD_TEST_READY,
    TCBD_CMD_READ_SENSE,
    TCBD_CMD_DEFINE_PARAMS,
    TCBD_CMD_WRITE_BUFFER,
    TCBD_CMD_READ_BUFFER,
    TCBD_CMD_REWIND,
    TCBD_CMD_READ_BLOCKS,
    TCBD_CMD_WRITE_BLOCKS,
    TCBD_CMD_WRITE_MARK,
    TCBD_CMD_READ_MARKS,
    TCBD_CMD_READ_EXT_STATUS,
    TCBD_CMD_ERASE,
    TCBD_CMD_RETENSION,
    TCBD_CMD_FIND_END,
    TCBD_CMD_DIAGNOSTICS
  } tcbd_cmd_t;

endpackage

/* File: tcbd_opcode_lookup.sv */
/*
  Pure combinational opcode lookup for the command block decoder.
  Assumes the caller registers the result; no state here.
*/
`timescale 1ns/1ns
module tcbd_opcode_lookup (
  input wire logic [7:0] opcode,
  output tcbd_pkg::tcbd_cmd_t cmd,
  output logic known
);

  // ==========================================================
  // opcode table
  always_comb begin
    known = 1'b1;
    unique case (opcode)
      tcbd_pkg::OP_REWIND: cmd = tcbd_pkg::TCBD_CMD_REWIND;
      tcbd_pkg::OP_READ_MARKS: cmd = tcbd_pkg::TCBD_CMD_READ_MARKS;
      tcbd_pkg::OP_ERASE: cmd = tcbd_pkg::TCBD_CMD_ERASE;
      tcbd_pkg::OP_RETENSION: cmd = tcbd_pkg::TCBD_CMD_RETENSION;
      tcbd_pkg::OP_FIND_END: cmd = tcbd_pkg::TCBD_CMD_FIND_END;
      tcbd_pkg::OP_READ_SENSE: cmd = tcbd_pkg::TCBD_CMD_READ_SENSE;
      tcbd_pkg::OP_WRITE_BUFFER: cmd = tcbd_pkg::TCBD_CMD_WRITE_BUFFER;
      tcbd_pkg::OP_READ_BUFFER: cmd = tcbd_pkg::TCBD_CMD_READ_BUFFER;
      tcbd_pkg::OP_READ_BLOCKS: cmd = tcbd_pkg::TCBD_CMD_READ_BLOCKS;
      tcbd_pkg::OP_WRITE_BLOCKS: cmd = tcbd_pkg::TCBD_CMD_WRITE_BLOCKS;
      tcbd_pkg::OP_WRITE_MARK: cmd = tcbd_pkg::TCBD_CMD_WRITE_MARK;
      tcbd_pkg::OP_READ_EXT_STATUS: cmd = tcbd_pkg::TCBD_CMD_READ_EXT_STATUS;
      tcbd_pkg::OP_TEST_READY: cmd = tcbd_pkg::TCBD_CMD_TEST_READY;
      tcbd_pkg::OP_DEFINE_PARAMS: cmd = tcbd_pkg::TCBD_CMD_DEFINE_PARAMS;
      tcbd_pkg::OP_DIAGNOSTICS: cmd = tcbd_pkg::TCBD_CMD_DIAGNOSTICS;
      // anything else is an illegal command
      default: begin
        cmd = tcbd_pkg::TCBD_CMD_NONE;
        known = 1'b0;
      end
    endcase
  end

endmodule // tcbd_opcode_lookup

/* File: tcbd_decoder.sv */
/*
  Six-byte tape command block collector and decoder.
  Assumes bytes arrive as single-cycle strobes from logic on SYS_CLK;
  the execution logic downstream consumes one-cycle command pulses.
*/
`timescale 1ns/1ns

module tcbd_decoder #(
  parameter int ADDR_W = 21,
  parameter int PAGE_W = 4
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  output logic BYTE_READY,
  output logic CMD_VALID,
  output logic [3:0] CMD_ID,
  output logic [7:0] CMD_OPCODE,
  output logic [2:0] CMD_CLASS,
  output logic [4:0] CMD_FUNCTION,
  output logic CLASS_DEFINED,
  output logic [2:0] CMD_UNIT,
  output logic [ADDR_W-1:0] BLOCK_ADDRESS,
  output logic [7:0] MARK_SKIP_COUNT,
  output logic [7:0] MARK_WRITE_COUNT,
  output logic [7:0] BLOCK_COUNT,
  output logic [PAGE_W-1:0] BUFFER_PAGE,
  output logic REPOSITION,
  output logic FLUSH,
  output logic UNDERRUN_CONTINUE,
  output logic THRESHOLD,
  output logic HIGH_CURRENT,
  output logic CLEAR_COUNTERS,
  output logic MOTION_ALLOWED,
  output logic ILLEGAL_COMMAND
);

  // ==========================================================
  // state
  typedef enum logic [0:0] {
    TCBD_COLLECT,
    TCBD_ISSUE
  } tcbd_phase_t;

  typedef struct packed {
    tcbd_phase_t phase;
    logic ready; // own flop so that BYTE_READY is not decoded from the phase
    logic [2:0] idx;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic cmd_valid;
    logic [3:0] cmd_id;
    logic [7:0] opcode;
    logic [2:0] cls;
    logic [4:0] func;
    logic class_ok;
    logic [2:0] unit;
    logic [ADDR_W-1:0] addr;
    logic [7:0] skip_cnt;
    logic [7:0] mark_cnt;
    logic [7:0] blk_cnt;
    logic [PAGE_W-1:0] page;
    logic repos;
    logic flush;
    logic underrun;
    logic thresh;
    logic high_cur;
    logic clr_cnt;
    logic motion;
    logic illegal;
  } tcbd_state_t;

  tcbd_state_t st;
  tcbd_state_t next_st;

  tcbd_pkg::tcbd_cmd_t look_cmd;
  logic look_known;

  // ==========================================================
  // opcode lookup on the held first byte
  tcbd_opcode_lookup u_lookup (
    .opcode(st.b0),
    .cmd(look_cmd),
    .known(look_known)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    logic is_rd;
    logic is_wr;
    logic is_wm;
    logic is_rm;
    logic is_fe;
    logic is_buf;
    logic is_stat;
    logic is_pos;
    is_rd = 1'b0;
    is_wr = 1'b0;
    is_wm = 1'b0;
    is_rm = 1'b0;
    is_fe = 1'b0;
    is_buf = 1'b0;
    is_stat = 1'b0;
    is_pos = 1'b0;
    next_st = st;
    next_st.cmd_valid = 1'b0;
    unique case (st.phase)
      // byte collection; the decode waits for the sixth byte
      TCBD_COLLECT: begin
        if (BYTE_VALID) begin
          unique case (st.idx)
            tcbd_pkg::IDX_OPCODE: next_st.b0 = BYTE_DATA;
            tcbd_pkg::IDX_UNIT_HI: next_st.b1 = BYTE_DATA;
            tcbd_pkg::IDX_ADDR_MID: next_st.b2 = BYTE_DATA;
            tcbd_pkg::IDX_ADDR_LO: next_st.b3 = BYTE_DATA;
            tcbd_pkg::IDX_COUNT: next_st.b4 = BYTE_DATA;
            default: next_st.b5 = BYTE_DATA;
          endcase
          if (st.idx == tcbd_pkg::IDX_OPTION) begin
            next_st.idx = tcbd_pkg::IDX_OPCODE;
            next_st.phase = TCBD_ISSUE;
            // intake closes for the decode cycle, so a seventh byte waits
            next_st.ready = 1'b0;
          end else begin
            next_st.idx = st.idx + 3'h1;
          end
        end
      end
      // one decode cycle; byte intake is held off meanwhile
      TCBD_ISSUE: begin
        is_rd = (look_cmd == tcbd_pkg::TCBD_CMD_READ_BLOCKS);
        is_wr = (look_cmd == tcbd_pkg::TCBD_CMD_WRITE_BLOCKS);
        is_wm = (look_cmd == tcbd_pkg::TCBD_CMD_WRITE_MARK);
        is_rm = (look_cmd == tcbd_pkg::TCBD_CMD_READ_MARKS);
        is_fe = (look_cmd == tcbd_pkg::TCBD_CMD_FIND_END);
        is_buf = (look_cmd == tcbd_pkg::TCBD_CMD_WRITE_BUFFER) ||
                 (look_cmd == tcbd_pkg::TCBD_CMD_READ_BUFFER);
        is_stat = (look_cmd == tcbd_pkg::TCBD_CMD_READ_SENSE) ||
                  (look_cmd == tcbd_pkg::TCBD_CMD_READ_EXT_STATUS);
        is_pos = (look_cmd == tcbd_pkg::TCBD_CMD_REWIND) || is_rm ||
                 (look_cmd == tcbd_pkg::TCBD_CMD_ERASE) ||
                 (look_cmd == tcbd_pkg::TCBD_CMD_RETENSION) || is_fe;
        next_st.phase = TCBD_COLLECT;
        next_st.ready = 1'b1;
        next_st.cmd_valid = 1'b1;
        next_st.cmd_id = look_cmd;
        next_st.opcode = st.b0;
        next_st.cls = st.b0[tcbd_pkg::CLASS_MSB:tcbd_pkg::CLASS_LSB];
        next_st.class_ok = (st.b0[tcbd_pkg::CLASS_MSB:tcbd_pkg::CLASS_LSB] != 3'h3) &&
                           (st.b0[tcbd_pkg::CLASS_MSB:tcbd_pkg::CLASS_LSB] != 3'h4) &&
                           (st.b0[tcbd_pkg::CLASS_MSB:tcbd_pkg::CLASS_LSB] != 3'h5) &&
                           (st.b0[tcbd_pkg::CLASS_MSB:tcbd_pkg::CLASS_LSB] != 3'h6);
        next_st.func = st.b0[tcbd_pkg::FUNC_MSB:0];
        // buffer and diagnostic commands always address unit zero
        next_st.unit = (is_buf || look_cmd == tcbd_pkg::TCBD_CMD_DIAGNOSTICS) ? 3'h0
                       : st.b1[tcbd_pkg::UNIT_MSB:tcbd_pkg::UNIT_LSB];
        // only the block read carries an address; positioning forces zero
        next_st.addr = (is_rd && !is_pos) ? ADDR_W'({st.b1[tcbd_pkg::ADDR_HI_MSB:0], st.b2, st.b3})
                       : '0;
        // the count byte means marks or blocks depending on the command
        next_st.skip_cnt = is_rm ? st.b4 : 8'h00;
        next_st.mark_cnt = is_wm ? st.b4 : 8'h00;
        next_st.blk_cnt = (is_rd || is_wr) ? st.b4 : 8'h00;
        next_st.page = is_buf ? PAGE_W'(st.b5[tcbd_pkg::OPT_PAGE_MSB:0]) : '0;
        // option bits act only for the commands that define them
        next_st.repos = is_rd && st.b5[tcbd_pkg::OPT_REPOSITION];
        // reposition implies a flush as well
        next_st.flush = is_rd && (st.b5[tcbd_pkg::OPT_FLUSH] ||
                        st.b5[tcbd_pkg::OPT_REPOSITION]);
        next_st.underrun = is_wr && st.b5[tcbd_pkg::OPT_UNDERRUN];
        next_st.thresh = (is_fe || is_rd || is_wr || is_rm || is_wm) &&
                         st.b5[tcbd_pkg::OPT_THRESHOLD];
        next_st.high_cur = (is_wr || is_wm) && st.b5[tcbd_pkg::OPT_HIGH_CURRENT];
        next_st.clr_cnt = is_stat && st.b5[tcbd_pkg::OPT_CLEAR_COUNTERS];
        // an unknown opcode must never start the tape
        next_st.illegal = !look_known;
        next_st.motion = look_known;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st <= '{phase: TCBD_COLLECT, ready: 1'b1, cmd_id: 4'h0, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from state flops
  assign BYTE_READY = st.ready;
  assign CMD_VALID = st.cmd_valid;
  assign CMD_ID = st.cmd_id;
  assign CMD_OPCODE = st.opcode;
  assign CMD_CLASS = st.cls;
  assign CMD_FUNCTION = st.func;
  assign CLASS_DEFINED = st.class_ok;
  assign CMD_UNIT = st.unit;
  assign BLOCK_ADDRESS = st.addr;
  assign MARK_SKIP_COUNT = st.skip_cnt;
  assign MARK_WRITE_COUNT = st.mark_cnt;
  assign BLOCK_COUNT = st.blk_cnt;
  assign BUFFER_PAGE = st.page;
  assign REPOSITION = st.repos;
  assign FLUSH = st.flush;
  assign UNDERRUN_CONTINUE = st.underrun;
  assign THRESHOLD = st.thresh;
  assign HIGH_CURRENT = st.high_cur;
  assign CLEAR_COUNTERS = st.clr_cnt;
  assign MOTION_ALLOWED = st.motion;
  assign ILLEGAL_COMMAND = st.illegal;

endmodule // tcbd_decoder

/* File: tcbd_decoder_asserts.sv */
/*
  Port checker for the command block decoder.
  Assumes it is bound onto tcbd_decoder with one clock and async reset.
*/
`timescale 1ns/1ns
module tcbd_decoder_asserts #(
  parameter int ADDR_W = 21,
  parameter int PAGE_W = 4
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  input wire logic BYTE_READY,
  input wire logic CMD_VALID,
  input wire logic [3:0] CMD_ID,
  input wire logic [7:0] CMD_OPCODE,
  input wire logic [2:0] CMD_CLASS,
  input wire logic [4:0] CMD_FUNCTION,
  input wire logic CLASS_DEFINED,
  input wire logic [ADDR_W-1:0] BLOCK_ADDRESS,
  input wire logic [7:0] BLOCK_COUNT,
  input wire logic REPOSITION,
  input wire logic FLUSH,
  input wire logic MOTION_ALLOWED,
  input wire logic ILLEGAL_COMMAND
);
  // =====
  // helper: byte position and the last six bytes taken
  logic [2:0] n;
  logic [47:0] sh;
  wire take = BYTE_VALID && BYTE_READY;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      n <= 3'h0;
      sh <= '0;
    end else if (take) begin
      n <= (n == 3'h5) ? 3'h0 : n + 3'h1;
      sh <= {sh[39:0], BYTE_DATA};
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // =====
  // properties
  sequence s_sixth; take && n == 3'h5; endsequence
  sequence s_issue; !BYTE_READY && !CMD_VALID ##1 CMD_VALID && BYTE_READY; endsequence
  property p_issue; s_sixth |=> s_issue; endproperty
  property p_after; CMD_VALID |-> $past(BYTE_READY) == 1'b0; endproperty
  property p_pulse; CMD_VALID |=> !CMD_VALID; endproperty
  property p_op; CMD_VALID |-> CMD_OPCODE == sh[47:40] && CMD_CLASS == sh[47:45] && CMD_FUNCTION == sh[44:40]
    && CLASS_DEFINED == (sh[47:45] inside {3'h0, 3'h1, 3'h2, 3'h7}); endproperty
  property p_addr; CMD_VALID |-> BLOCK_ADDRESS == (sh[47:40] == 8'h21 ? ADDR_W'(sh[36:16]) : '0); endproperty
  property p_count; CMD_VALID |-> BLOCK_COUNT == (sh[47:40] inside {8'h21, 8'h22} ? sh[15:8] : 8'h00); endproperty
  property p_flush; CMD_VALID |-> FLUSH == (sh[47:40] == 8'h21 && sh[7:6] != 2'h0)
    && REPOSITION == (sh[47:40] == 8'h21 && sh[7]); endproperty
  property p_illegal; CMD_VALID |-> ILLEGAL_COMMAND == (CMD_ID == 4'h0) && MOTION_ALLOWED != ILLEGAL_COMMAND; endproperty
  property p_hold; !CMD_VALID |-> $stable({CMD_OPCODE, BLOCK_ADDRESS, BLOCK_COUNT, FLUSH}); endproperty
  a_issue: assert property (p_issue) else $error("command not issued after sixth byte");
  a_after: assert property (p_after) else $error("command pulse without issue cycle");
  a_pulse: assert property (p_pulse) else $error("command pulse longer than one cycle");
  a_op: assert property (p_op) else $error("opcode class or function wrong");
  a_addr: assert property (p_addr) else $error("block address wrong");
  a_count: assert property (p_count) else $error("block count wrong");
  a_flush: assert property (p_flush) else $error("flush or reposition wrong");
  a_illegal: assert property (p_illegal) else $error("illegal flag wrong");
  a_hold: assert property (p_hold) else $error("fields changed between commands");
endmodule // tcbd_decoder_asserts

bind tcbd_decoder tcbd_decoder_asserts #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) tcbd_chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA),
  .BYTE_READY(BYTE_READY), .CMD_VALID(CMD_VALID), .CMD_ID(CMD_ID), .CMD_OPCODE(CMD_OPCODE),
  .CMD_CLASS(CMD_CLASS), .CMD_FUNCTION(CMD_FUNCTION), .CLASS_DEFINED(CLASS_DEFINED),
  .BLOCK_ADDRESS(BLOCK_ADDRESS), .BLOCK_COUNT(BLOCK_COUNT), .REPOSITION(REPOSITION),
  .FLUSH(FLUSH), .MOTION_ALLOWED(MOTION_ALLOWED), .ILLEGAL_COMMAND(ILLEGAL_COMMAND));

/* File: tcbd_host_model.sv */
/*
  Host model that offers command blocks one byte at a time.
  Assumes the decoder takes a byte at a rising edge while ready.
*/
`timescale 1ns/1ns
module tcbd_host_model (
  input wire logic sys_clk,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  // =====
  // idle state; data is inverted when idle so a stale byte never repeats
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  // send the first n bytes of blk in order, gap idle cycles between bytes
  task automatic send(input logic [47:0] blk, input int n, input int gap);
    @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      byte_valid <= 1'b1;
      byte_data <= blk[47 - 8 * i -: 8];
      do @(posedge sys_clk); while (byte_ready !== 1'b1);
      if (i < n - 1 && gap > 0) begin
        byte_valid <= 1'b0;
        byte_data <= ~blk[47 - 8 * i -: 8];
        repeat (gap) @(posedge sys_clk);
      end
    end
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
  endtask
endmodule // tcbd_host_model

/* File: test_tcbd_decoder.sv */
/*
  Self-checking bench for the command block decoder.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ns
module test_tcbd_decoder;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic byte_valid, byte_ready, cmd_valid, class_defined, reposition, flush, underrun_continue;
  logic threshold, high_current, clear_counters, motion_allowed, illegal_command;
  logic [7:0] byte_data, cmd_opcode, mark_skip_count, mark_write_count, block_count;
  logic [3:0] cmd_id, buffer_page;
  logic [4:0] cmd_function;
  logic [2:0] cmd_class, cmd_unit;
  logic [20:0] block_address;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // opcode, option byte, expected code; undefined option bits are zero
  logic [19:0] tbl [22] = '{20'h00001, 20'h03042, 20'h0c003, 20'h0f0f4, 20'h10055, 20'h11006,
    20'h21e07, 20'h22388, 20'h23309, 20'h2420a, 20'h2504b, 20'h2600c, 20'h2700d, 20'h2820e,
    20'he400f, 20'h21807, 20'h21407, 20'h22008, 20'h23109, 20'h60000, 20'hff000, 20'h01000};
  always #4 sys_clk = ~sys_clk;
  tcbd_decoder tcbd_decoder_inst (.SYS_CLK(sys_clk), .RESET(reset), .BYTE_VALID(byte_valid),
    .BYTE_DATA(byte_data), .BYTE_READY(byte_ready), .CMD_VALID(cmd_valid), .CMD_ID(cmd_id),
    .CMD_OPCODE(cmd_opcode), .CMD_CLASS(cmd_class), .CMD_FUNCTION(cmd_function),
    .CLASS_DEFINED(class_defined), .CMD_UNIT(cmd_unit), .BLOCK_ADDRESS(block_address),
    .MARK_SKIP_COUNT(mark_skip_count), .MARK_WRITE_COUNT(mark_write_count), .BLOCK_COUNT(block_count),
    .BUFFER_PAGE(buffer_page), .REPOSITION(reposition), .FLUSH(flush), .UNDERRUN_CONTINUE(underrun_continue),
    .THRESHOLD(threshold), .HIGH_CURRENT(high_current), .CLEAR_COUNTERS(clear_counters),
    .MOTION_ALLOWED(motion_allowed), .ILLEGAL_COMMAND(illegal_command));
  tcbd_host_model tcbd_host_model_inst (.sys_clk(sys_clk), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data));
  // =====
  // compare and close
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // send one block and compare every decoded field, except the unit of an unknown opcode, with its expected value
  task automatic run(input logic [47:0] b, input logic [3:0] id, input int gap);
    logic [7:0] op;
    logic [7:0] o;
    logic r;
    logic w;
    logic bf;
    int i;
    op = b[47:40];
    o = b[7:0];
    r = op == 8'h21;
    w = op == 8'h22;
    bf = op == 8'h0f || op == 8'h10;
    tcbd_host_model_inst.send(b, 6, gap);
    i = 0;
    do begin
      @(posedge sys_clk);
      #1;
      i++;
    end while (cmd_valid !== 1'b1 && i < 4);
    check("issue", {cmd_valid, i[2:0]}, 4'h9);
    check("id", cmd_id, id);
    check("opcode", {cmd_opcode, cmd_class, cmd_function}, {op, op});
    check("class", class_defined, op[7:5] inside {3'h0, 3'h1, 3'h2, 3'h7});
    if (id != 4'h0) check("unit", cmd_unit, (bf || op == 8'he4) ? 3'h0 : b[39:37]);
    check("address", block_address, r ? b[36:16] : 21'h0);
    check("skip", mark_skip_count, op == 8'h24 ? b[15:8] : 8'h00);
    check("marks", mark_write_count, op == 8'h23 ? b[15:8] : 8'h00);
    check("blocks", block_count, (r || w) ? b[15:8] : 8'h00);
    check("page", buffer_page, bf ? o[3:0] : 4'h0);
    check("reposition", reposition, r & o[7]);
    check("flush", flush, r & (o[7] | o[6]));
    check("underrun", underrun_continue, w & o[3]);
    check("threshold", threshold, o[5] & (op inside {8'h21, 8'h22, 8'h23, 8'h24, 8'h28}));
    check("current", high_current, o[4] & (w | op == 8'h23));
    check("clear", clear_counters, o[2] & (op == 8'h03 | op == 8'h25));
    check("motion", {motion_allowed, illegal_command}, {id != 4'h0, id == 4'h0});
    $display("test opcode %h done", op);
  endtask
  // cycle ceiling against a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  // main sequence: every opcode, option variants, reset inside a block
  initial begin
    repeat (12) @(posedge sys_clk);
    check("reset", {byte_ready, cmd_valid}, 2'h2);
    reset <= 1'b0;
    foreach (tbl[k]) run({tbl[k][19:12], 32'hb53cc39a, tbl[k][11:4]}, tbl[k][3:0], k % 3);
    tcbd_host_model_inst.send(48'h21b53cc39a80, 3, 0);
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
    run(48'h240000000720, 4'ha, 1);
    close_out();
  end
endmodule // test_tcbd_decoder
